// file: core/irt_pkg.sv
/*
 * Constants, types and timing figures for the interrupt response timing block.
 * Assumes a single 40 MHz CPU clock; bus and peripheral periods are given
 * in picoseconds and folded into whole CPU cycles here.
 */
`default_nettype none
package irt_pkg;
    localparam int CLK_PS  = 25000;
    localparam int ICYC_PS = 25000;
    localparam int BCYC_PS = 25000;
    localparam int PCYC_PS = 25000;

    // decision times, least times rounded up to whole CPU cycles
    localparam int NMI_DEC_PS  = ICYC_PS / 2 + BCYC_PS / 2 + PCYC_PS / 2;
    localparam int IRL_DEC_PS  = ICYC_PS / 2 + BCYC_PS / 2 + 2 * PCYC_PS;
    localparam int MOD_DEC_PS  = ICYC_PS / 2 + (3 * PCYC_PS) / 2;
    localparam int NMI_DEC_CYC = (NMI_DEC_PS + CLK_PS - 1) / CLK_PS;
    localparam int IRL_DEC_CYC = (IRL_DEC_PS + CLK_PS - 1) / CLK_PS;
    localparam int MOD_DEC_CYC = (MOD_DEC_PS + CLK_PS - 1) / CLK_PS;

    localparam int VEC_PS  = 5 * ICYC_PS;
    localparam int VEC_CYC = VEC_PS / CLK_PS;

    localparam int LVL_W = 5;
    localparam int MSK_W = 4;
    localparam logic [LVL_W-1:0] NMI_LEVEL   = 5'h10;
    localparam logic [LVL_W-1:0] LEVEL_RST   = 5'h00;
    localparam logic [MSK_W-1:0] IRL_NONE_N  = 4'hF;
    localparam logic [2:0]       VCNT_RST    = 3'h0;
    localparam logic [2:0]       VCNT_LOAD   = 3'(VEC_CYC - 1);

    typedef enum logic [1:0] {
        CLS_NMI = 2'h0,
        CLS_IRL = 2'h1,
        CLS_MOD = 2'h2
    } src_class_e;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_WAIT = 4'h2,
        ST_SAVE = 4'h4,
        ST_VEC  = 4'h8
    } seq_state_e;
endpackage
`default_nettype wire

// file: core/irt_req_if.sv
/*
 * Accepted request from the arbiter to the exception sequencer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface irt_req_if;
    logic                      req_valid;
    logic [irt_pkg::LVL_W-1:0] level;
    irt_pkg::src_class_e       cls;
    logic                      nmi_ack;

    modport arb (output req_valid, output level, output cls, input nmi_ack);
    modport seq (input req_valid, input level, input cls, output nmi_ack);
endinterface
`default_nettype wire

// file: core/irt_arbiter.sv
/*
 * Priority decision and mask comparison with per-class decision delay.
 * Assumes inputs already synchronised to the CPU clock.
 */
`timescale 1ns/10ps
`default_nettype none
module irt_arbiter (
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      nmi_edge_i,
    input  wire logic [irt_pkg::MSK_W-1:0] irl_n_i,
    input  wire logic                      mod_req_i,
    input  wire logic [irt_pkg::MSK_W-1:0] mod_level_i,
    input  wire logic [irt_pkg::MSK_W-1:0] mask_i,
    irt_req_if.arb                         req
);
    localparam int IW = irt_pkg::IRL_DEC_CYC - 1;
    localparam int MW = irt_pkg::MOD_DEC_CYC - 1;

    logic                      nmi_pend_q;
    logic [irt_pkg::MSK_W-1:0] irl_pipe_q [IW];
    logic [irt_pkg::MSK_W:0]   mod_pipe_q [MW];
    logic [irt_pkg::MSK_W-1:0] irl_lvl;
    logic                      sel_valid;
    logic [irt_pkg::LVL_W-1:0] sel_level;
    irt_pkg::src_class_e       sel_cls;
    logic                      mod_v;
    logic [irt_pkg::MSK_W-1:0] mod_l;
    logic [irt_pkg::MSK_W-1:0] irl_t;

    assign irl_lvl = ~irl_n_i;
    assign mod_v   = mod_pipe_q[MW-1][irt_pkg::MSK_W];
    assign mod_l   = mod_pipe_q[MW-1][irt_pkg::MSK_W-1:0];
    assign irl_t   = irl_pipe_q[IW-1];

    // an edge in the same cycle as the ack stays pending; the pending flag is
    // the first of the pin's two decision stages, the output flop the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            nmi_pend_q <= 1'b0;
        end else if (nmi_edge_i) begin
            nmi_pend_q <= 1'b1;
        end else if (req.nmi_ack) begin
            nmi_pend_q <= 1'b0;
        end
    end

    // delay lines realise the decision time, output flop is the last stage
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < IW; i++) begin
                irl_pipe_q[i] <= '0;
            end
            for (int i = 0; i < MW; i++) begin
                mod_pipe_q[i] <= '0;
            end
        end else begin
            irl_pipe_q[0] <= irl_lvl;
            for (int i = 1; i < IW; i++) begin
                irl_pipe_q[i] <= irl_pipe_q[i-1];
            end
            mod_pipe_q[0] <= {mod_req_i, mod_level_i};
            for (int i = 1; i < MW; i++) begin
                mod_pipe_q[i] <= mod_pipe_q[i-1];
            end
        end
    end

    // ties between pin levels and modules go to the pins
    always_comb begin
        sel_valid = 1'b0;
        sel_level = irt_pkg::LEVEL_RST;
        sel_cls   = irt_pkg::CLS_MOD;
        if (nmi_pend_q) begin
            sel_valid = 1'b1;
            sel_level = irt_pkg::NMI_LEVEL;
            sel_cls   = irt_pkg::CLS_NMI;
        end else if (irl_t != '0 && (!mod_v || irl_t >= mod_l)) begin
            sel_valid = 1'b1;
            sel_level = {1'b0, irl_t};
            sel_cls   = irt_pkg::CLS_IRL;
        end else if (mod_v && mod_l != '0) begin
            sel_valid = 1'b1;
            sel_level = {1'b0, mod_l};
            sel_cls   = irt_pkg::CLS_MOD;
        end
        // strictly greater than the mask; the non-maskable pin bypasses it
        if (sel_cls != irt_pkg::CLS_NMI && sel_level <= {1'b0, mask_i}) begin
            sel_valid = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req.req_valid <= 1'b0;
            req.level     <= irt_pkg::LEVEL_RST;
            req.cls       <= irt_pkg::CLS_MOD;
        end else begin
            req.req_valid <= sel_valid;
            req.level     <= sel_level;
            req.cls       <= sel_cls;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_mask_strict: assert property (
        req.req_valid && req.cls != irt_pkg::CLS_NMI |-> req.level > {1'b0, $past(mask_i)})
        else $error("maskable request forwarded at or below mask");
    a_nmi_decision: assert property (
        nmi_edge_i |-> ##2 (req.req_valid && req.cls == irt_pkg::CLS_NMI))
        else $error("nmi decision time wrong");
    a_irl_decision: assert property (
        ($past(irl_lvl) == '0 && irl_lvl != '0 && mask_i == '0)
        ##0 (irl_lvl != '0 && mask_i == '0) [*3] |=> req.req_valid)
        else $error("level input decision time exceeded");
    a_mod_decision: assert property (
        (!$past(mod_req_i) && mod_req_i && mod_level_i != '0 && mask_i == '0)
        ##0 (mod_req_i && mod_level_i != '0 && mask_i == '0) [*2] |=> req.req_valid)
        else $error("module decision time exceeded");
    a_irl_not_early: assert property (
        $past(irl_lvl) == '0 && irl_lvl != '0 && !nmi_pend_q && !mod_req_i
        && !mod_pipe_q[0][irt_pkg::MSK_W] && irl_pipe_q[0] == '0 && irl_t == '0
        |=> !req.req_valid)
        else $error("level input forwarded too early");
endmodule
`default_nettype wire

// file: core/interrupt_response_timing.sv
/*
 * Interrupt acceptance and exception entry sequencer: synchronises the pins,
 * runs the arbiter and paces entry into the handler.
 * Assumes the CPU gives an instruction-end strobe and status word fields on
 * the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module interrupt_response_timing (
    input  wire logic                      CLOCK_I,
    input  wire logic                      ARST_N_I,
    input  wire logic                      NMI_I,
    input  wire logic [irt_pkg::MSK_W-1:0] IRL_N_I,
    input  wire logic                      MOD_REQ_I,
    input  wire logic [irt_pkg::MSK_W-1:0] MOD_LEVEL_I,
    input  wire logic [irt_pkg::MSK_W-1:0] INTERRUPT_MASK_LEVEL_I,
    input  wire logic                      EXCEPTION_BLOCK_FLAG_I,
    input  wire logic                      INSN_END_I,
    input  wire logic                      NEXT_INSN_MASKS_I,
    output logic                           IRQ_REQUEST_O,
    output logic                           SAVE_CONTEXT_O,
    output logic                           HANDLER_FETCH_O,
    output logic [irt_pkg::LVL_W-1:0]      TAKEN_LEVEL_O,
    output logic [1:0]                     TAKEN_CLASS_O
);
    logic                      rst_s1_q;
    logic                      rst_n;
    logic                      nmi_s1_q;
    logic                      nmi_s2_q;
    logic                      nmi_s3_q;
    logic [irt_pkg::MSK_W-1:0] irl_s1_q;
    logic [irt_pkg::MSK_W-1:0] irl_s2_q;
    logic                      nmi_edge;
    irt_pkg::seq_state_e       state_q;
    logic [2:0]                vcnt_q;
    logic                      save_q;
    logic                      fetch_q;
    logic                      take;

    irt_req_if req ();

    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // pins cross from outside; nothing reads the first stage but the second
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            nmi_s1_q <= 1'b0;
            nmi_s2_q <= 1'b0;
            nmi_s3_q <= 1'b0;
            irl_s1_q <= irt_pkg::IRL_NONE_N;
            irl_s2_q <= irt_pkg::IRL_NONE_N;
        end else begin
            nmi_s1_q <= NMI_I;
            nmi_s2_q <= nmi_s1_q;
            nmi_s3_q <= nmi_s2_q;
            irl_s1_q <= IRL_N_I;
            irl_s2_q <= irl_s1_q;
        end
    end

    assign nmi_edge = nmi_s2_q && !nmi_s3_q;

    irt_arbiter u_arb (
        .clk_i       (CLOCK_I),
        .rst_n_i     (rst_n),
        .nmi_edge_i  (nmi_edge),
        .irl_n_i     (irl_s2_q),
        .mod_req_i   (MOD_REQ_I),
        .mod_level_i (MOD_LEVEL_I),
        .mask_i      (INTERRUPT_MASK_LEVEL_I),
        .req         (req.arb)
    );

    // entry only at an instruction boundary with the block flag clear
    // and no masking instruction following
    // the wait is bounded by the CPU's longest instruction, the status word
    // postinc load at seven cycles plus memory waits
    assign take = req.req_valid && INSN_END_I && !EXCEPTION_BLOCK_FLAG_I
                  && !NEXT_INSN_MASKS_I;

    assign req.nmi_ack = save_q && TAKEN_CLASS_O == 2'(irt_pkg::CLS_NMI);

    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= irt_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                irt_pkg::ST_IDLE: begin
                    if (req.req_valid) begin
                        state_q <= irt_pkg::ST_WAIT;
                    end
                end
                irt_pkg::ST_WAIT: begin
                    if (!req.req_valid) begin
                        state_q <= irt_pkg::ST_IDLE;
                    end else if (take) begin
                        state_q <= irt_pkg::ST_SAVE;
                    end
                end
                irt_pkg::ST_SAVE: begin
                    state_q <= irt_pkg::ST_VEC;
                end
                irt_pkg::ST_VEC: begin
                    if (vcnt_q == 3'h1) begin
                        state_q <= irt_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= irt_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // save to first fetch is a fixed count for every class
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            vcnt_q <= irt_pkg::VCNT_RST;
        end else if (state_q == irt_pkg::ST_SAVE) begin
            vcnt_q <= irt_pkg::VCNT_LOAD;
        end else if (state_q == irt_pkg::ST_VEC) begin
            vcnt_q <= vcnt_q - 3'h1;
        end
    end

    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            save_q  <= 1'b0;
            fetch_q <= 1'b0;
        end else begin
            save_q  <= state_q == irt_pkg::ST_WAIT && take;
            fetch_q <= state_q == irt_pkg::ST_VEC && vcnt_q == 3'h1;
        end
    end

    // level and class frozen at save so the handler sees what was taken
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            TAKEN_LEVEL_O <= irt_pkg::LEVEL_RST;
            TAKEN_CLASS_O <= 2'(irt_pkg::CLS_MOD);
        end else if (state_q == irt_pkg::ST_WAIT && take) begin
            TAKEN_LEVEL_O <= req.level;
            TAKEN_CLASS_O <= 2'(req.cls);
        end
    end

    // totals are decision + wait + entry; with one clock the bus and
    // peripheral ratios are fixed at 1:1:1, so the quarter-rate figures only
    // bound the design from above
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            IRQ_REQUEST_O <= 1'b0;
        end else begin
            IRQ_REQUEST_O <= req.req_valid;
        end
    end

    assign SAVE_CONTEXT_O  = save_q;
    assign HANDLER_FETCH_O = fetch_q;

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!rst_n);

    a_block_holds_off: assert property (
        state_q == irt_pkg::ST_WAIT && EXCEPTION_BLOCK_FLAG_I |=> !save_q)
        else $error("entry taken while block flag set");
    a_boundary_take: assert property (
        state_q == irt_pkg::ST_WAIT && req.req_valid && INSN_END_I
        && !EXCEPTION_BLOCK_FLAG_I && !NEXT_INSN_MASKS_I |=> save_q)
        else $error("entry not taken at instruction end");
    a_only_at_end: assert property (
        state_q == irt_pkg::ST_WAIT && !INSN_END_I |=> !save_q)
        else $error("entry taken mid instruction");
    a_inhibit_defers: assert property (
        state_q == irt_pkg::ST_WAIT && NEXT_INSN_MASKS_I |=> !save_q)
        else $error("entry taken under masking instruction");
    a_save_fetch_gap: assert property (
        save_q |=> (!fetch_q && !save_q) [*4] ##1 fetch_q)
        else $error("save to fetch is not five cycles");
    a_fetch_has_save: assert property (
        $rose(fetch_q) |-> $past(save_q, 5))
        else $error("fetch without save five cycles earlier");

    c_nmi_entry: cover property (save_q && TAKEN_CLASS_O == 2'(irt_pkg::CLS_NMI));
    c_irl_entry: cover property (save_q && TAKEN_CLASS_O == 2'(irt_pkg::CLS_IRL));
    c_mod_entry: cover property (save_q && TAKEN_CLASS_O == 2'(irt_pkg::CLS_MOD));
    c_block_then_take: cover property (
        state_q == irt_pkg::ST_WAIT && EXCEPTION_BLOCK_FLAG_I ##[1:20] save_q);
endmodule
`default_nettype wire

// file: tb/cpu_model.sv
/*
 * Behavioural model of the CPU side: instruction-end strobes and the
 * exception block flag.
 * Assumes it shares the block's clock and reset and drives on falling edges.
 */
`timescale 1ns/10ps
`default_nettype none
module cpu_model (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [2:0] s_len_i,
    input  wire logic       clear_blk_i,
    input  wire logic       save_i,
    output logic            insn_end_o,
    output logic            block_o
);
    logic [2:0] cnt_q;
    logic       last;

    // s_len_i of seven stands for the longest status word load
    assign last = ({1'b0, cnt_q} + 4'h1) >= {1'b0, s_len_i};

    always_ff @(negedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q      <= 3'h0;
            insn_end_o <= 1'b0;
        end else begin
            cnt_q      <= last ? 3'h0 : cnt_q + 3'h1;
            insn_end_o <= last;
        end
    end

    // flag set by entry, cleared only as a clearing instruction ends
    always_ff @(negedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            block_o <= 1'b0;
        end else if (save_i) begin
            block_o <= 1'b1;
        end else if (last && clear_blk_i) begin
            block_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
/*
 * Self-checking bench for interrupt acceptance and handler entry timing.
 * Assumes the design package is compiled first; inputs change on falling edges.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic       clk, arst_n, nmi, mod_req, next_masks, clear_blk;
    logic       insn_end, block, irq, save, fetch, hist;
    logic [3:0] irl_n, mod_lvl, msk;
    logic [2:0] s_len;
    logic [4:0] t_lvl;
    logic [1:0] t_cls;
    int         fails, comparisons, n, lat_mod, lat_irl, lat_nmi, lvl;
    int         cl[3] = '{15, 4, 1};
    int         cm[3] = '{14, 4, 0};

    interrupt_response_timing uut (
        .CLOCK_I(clk), .ARST_N_I(arst_n), .NMI_I(nmi), .IRL_N_I(irl_n),
        .MOD_REQ_I(mod_req), .MOD_LEVEL_I(mod_lvl), .INTERRUPT_MASK_LEVEL_I(msk),
        .EXCEPTION_BLOCK_FLAG_I(block), .INSN_END_I(insn_end),
        .NEXT_INSN_MASKS_I(next_masks), .IRQ_REQUEST_O(irq), .SAVE_CONTEXT_O(save),
        .HANDLER_FETCH_O(fetch), .TAKEN_LEVEL_O(t_lvl), .TAKEN_CLASS_O(t_cls));

    cpu_model cpu (
        .clk_i(clk), .rst_n_i(arst_n), .s_len_i(s_len), .clear_blk_i(clear_blk),
        .save_i(save), .insn_end_o(insn_end), .block_o(block));

    // strobe at the last edge: when save shows, that edge was the take edge
    always @(posedge clk) hist <= insn_end;

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic conclude();
        if (fails == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick();
        @(negedge clk);
    endtask

    function automatic logic pick(input int w);
        return w == 0 ? irq : (w == 1 ? save : fetch);
    endfunction

    task automatic wait_sig(input int w, output int k);
        k = 0;
        do begin
            tick();
            k++;
            if (k > 300) begin
                fails++;
                conclude();
            end
        end while (pick(w) !== 1'b1);
    endtask

    task automatic quiet(input int w, input int cycles);
        int hits;
        hits = 0;
        repeat (cycles) begin
            tick();
            if (pick(w) === 1'b1) hits++;
        end
        check("held off", 8'(hits), 8'h00);
    endtask

    task automatic post(input int c, input logic [3:0] l);
        case (c)
            0: nmi = 1'b1;
            1: irl_n = ~l;
            default: begin
                mod_req = 1'b1;
                mod_lvl = l;
            end
        endcase
    endtask

    task automatic entry(input logic [4:0] l, input logic [1:0] c, input bit bnd);
        int k;
        wait_sig(1, k);
        if (bnd) check("entry wait", 8'(k <= s_len + 2), 8'h01);
        check("entry boundary", {7'h00, hist}, 8'h01);
        check("taken level", {3'h0, t_lvl}, {3'h0, l});
        check("taken class", {6'h00, t_cls}, {6'h00, c});
        wait_sig(2, k);
        check("save to fetch", 8'(k), 8'h05);
    endtask

    task automatic drop();
        mod_req = 1'b0;
        mod_lvl = 4'h0;
        irl_n = 4'hF;
        nmi = 1'b0;
        repeat (8) tick();
    endtask

    task automatic unblock();
        int k;
        k = 0;
        clear_blk = 1'b1;
        while (block !== 1'b0 && k < 20) begin
            tick();
            k++;
        end
        clear_blk = 1'b0;
        if (k >= 20) begin
            fails++;
            conclude();
        end
    endtask

    initial begin
        fails = 0;
        comparisons = 0;
        arst_n = 1'b0;
        nmi = 1'b0;
        mod_req = 1'b0;
        mod_lvl = 4'h0;
        irl_n = 4'hF;
        msk = 4'h0;
        next_masks = 1'b0;
        clear_blk = 1'b0;
        s_len = 3'h7;
        void'($urandom(96304));
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) tick();
        post(2, 4'h5);
        wait_sig(0, lat_mod);
        // one edge more than the decision for the registered request output
        check("module latency", 8'(lat_mod), 8'(irt_pkg::MOD_DEC_CYC + 1));
        entry(5'h05, 2'h2, 1'b1);
        drop();
        unblock();
        post(1, 4'h9);
        wait_sig(0, lat_irl);
        // pins add two synchroniser edges ahead of the decision
        check("level latency", 8'(lat_irl), 8'(irt_pkg::IRL_DEC_CYC + 3));
        entry(5'h09, 2'h1, 1'b1);
        drop();
        unblock();
        post(0, 4'h0);
        wait_sig(0, lat_nmi);
        check("nmi latency", 8'(lat_nmi), 8'(irt_pkg::NMI_DEC_CYC + 3));
        entry(5'h10, 2'h0, 1'b1);
        check("nmi before irl", 8'(lat_nmi < lat_irl), 8'h01);
        check("module before irl", 8'(lat_mod < lat_irl), 8'h01);
        drop();
        // flag is still set by the last entry, so this request must wait
        post(2, 4'h7);
        quiet(1, 30);
        next_masks = 1'b1;
        unblock();
        quiet(1, 30);
        next_masks = 1'b0;
        entry(5'h07, 2'h2, 1'b0);
        drop();
        unblock();
        for (int i = 0; i < 16; i++) begin
            s_len = 3'($urandom_range(7, 1));
            msk = 4'(i < 3 ? cm[i] : $urandom_range(15, 0));
            lvl = i < 3 ? cl[i] : $urandom_range(15, 1);
            post(i % 2 + 1, 4'(lvl));
            if (lvl > int'(msk)) begin
                wait_sig(0, n);
                entry({1'b0, 4'(lvl)}, 2'(i % 2 + 1), 1'b1);
            end else begin
                quiet(0, 12);
            end
            drop();
            unblock();
        end
        conclude();
    end
endmodule
`default_nettype wire
